// File: sdp_dma.sv
module sdp_dma #(
  parameter int HALF_DIV = sdp_pkg::SCK_HALF_DIV
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // RAM port shared with the CPU
  output sdp_pkg::sdp_mem_req_t      mem_req,
  input  wire logic                  mem_gnt,
  input  wire logic [7:0]            mem_rdata,
  // Port flag
  output logic                       serial_port_irq_flag,
  // Serial pins
  input  wire logic                  sck_in,
  input  wire logic                  sdi,
  output logic                       sck_out,
  output logic                       sck_oe,
  output logic                       sdo
);

  logic [7:0]  ctrl1_r, ctrl1_nxt;
  logic [7:0]  ctrl2_r, ctrl2_nxt;
  logic [9:0]  cnt_r, cnt_nxt;
  logic [11:0] txp_r, txp_nxt, txb_r, txb_nxt;
  logic [11:0] rxp_r, rxp_nxt, rxb_r, rxb_nxt;
  logic        irq_r, irq_nxt;
  logic        wm_done_r, wm_done_nxt;
  logic [7:0]  txd_r, txd_nxt;
  sdp_pkg::sdp_state_t st_r, st_nxt;
  sdp_pkg::sdp_mem_req_t mreq_nxt;
  logic        wr, rd, sh_start, sh_done;
  logic [7:0]  sh_rx;
  logic [1:0]  dir;
  logic        use_tx, use_rx, run;
  logic [10:0] remain, level;
  logic        tx_prot, rx_prot;

  assign dir    = ctrl1_r[sdp_pkg::CTRL1_DIR_LO +: 2];
  assign use_tx = (dir == sdp_pkg::DIR_DUPLEX) || (dir == sdp_pkg::DIR_TX);
  assign use_rx = (dir == sdp_pkg::DIR_DUPLEX) || (dir == sdp_pkg::DIR_RX);
  assign run    = ctrl1_r[sdp_pkg::CTRL1_RUN];
  assign remain = {1'b0, cnt_r} + 11'h001;
  assign level  = {1'b0, sdp_pkg::wm_level(ctrl2_r[3:0])};
  assign tx_prot = (txp_r[11:8] == sdp_pkg::BANK_SFR_LO) ||
                   (txp_r[11:8] == sdp_pkg::BANK_SFR_HI);
  assign rx_prot = (rxp_r[11:8] == sdp_pkg::BANK_SFR_LO) ||
                   (rxp_r[11:8] == sdp_pkg::BANK_SFR_HI);

  //////////////////////////////////////////////////////////////////////////
  // APB access
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd && !penable) begin
      unique case (paddr)
        sdp_pkg::OFF_CTRL1:  prdata <= {24'h000000, ctrl1_r};
        sdp_pkg::OFF_CTRL2:  prdata <= {24'h000000, ctrl2_r};
        sdp_pkg::OFF_COUNT:  prdata <= {22'h0, cnt_r};
        sdp_pkg::OFF_TXPTR:  prdata <= {20'h00000, txp_r};
        sdp_pkg::OFF_RXPTR:  prdata <= {20'h00000, rxp_r};
        sdp_pkg::OFF_STATUS: prdata <= {30'h0, st_r != sdp_pkg::SDP_IDLE,
                                        irq_r};
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer and registers
  always_comb begin
    ctrl1_nxt   = ctrl1_r;
    ctrl2_nxt   = ctrl2_r;
    cnt_nxt     = cnt_r;
    txp_nxt     = txp_r;
    txb_nxt     = txb_r;
    rxp_nxt     = rxp_r;
    rxb_nxt     = rxb_r;
    irq_nxt     = irq_r;
    wm_done_nxt = wm_done_r;
    txd_nxt     = txd_r;
    st_nxt      = st_r;
    mreq_nxt    = '0;
    sh_start    = 1'b0;
    if (wr) begin
      unique case (paddr)
        sdp_pkg::OFF_CTRL1: ctrl1_nxt = pwdata[7:0];
        sdp_pkg::OFF_CTRL2: begin
          ctrl2_nxt = pwdata[7:0];
          if (run && {1'b0, sdp_pkg::wm_level(pwdata[3:0])} > remain) begin
            irq_nxt     = 1'b1;
            wm_done_nxt = 1'b1;
          end
        end
        sdp_pkg::OFF_COUNT: cnt_nxt = pwdata[9:0];
        sdp_pkg::OFF_TXPTR: begin
          if (pwdata[31]) txp_nxt[11:8] = pwdata[11:8];
          if (pwdata[30]) txp_nxt[7:0]  = pwdata[7:0];
          txb_nxt = txp_nxt;
        end
        sdp_pkg::OFF_RXPTR: begin
          if (pwdata[31]) rxp_nxt[11:8] = pwdata[11:8];
          if (pwdata[30]) rxp_nxt[7:0]  = pwdata[7:0];
          rxb_nxt = rxp_nxt;
        end
        sdp_pkg::OFF_STATUS: if (pwdata[sdp_pkg::STAT_IRQ]) irq_nxt = 1'b0;
        default: ;
      endcase
    end
    unique case (st_r)
      sdp_pkg::SDP_IDLE: begin
        wm_done_nxt = 1'b0;
        if (run) st_nxt = use_tx ? sdp_pkg::SDP_FETCH : sdp_pkg::SDP_SHIFT;
      end
      sdp_pkg::SDP_FETCH: begin
        if (tx_prot) begin
          txd_nxt = 8'h00;
          st_nxt  = sdp_pkg::SDP_SHIFT;
        end else begin
          mreq_nxt = '{req: 1'b1, we: 1'b0, addr: txp_r, wdata: 8'h00};
          if (mem_req.req && mem_gnt) begin
            mreq_nxt = '0;
            txd_nxt  = mem_rdata;
            st_nxt   = sdp_pkg::SDP_SHIFT;
          end
        end
      end
      sdp_pkg::SDP_SHIFT: begin
        sh_start = !sh_done;
        if (sh_done) st_nxt = use_rx ? sdp_pkg::SDP_STORE : sdp_pkg::SDP_NEXT;
      end
      sdp_pkg::SDP_STORE: begin
        if (rx_prot) begin
          st_nxt = sdp_pkg::SDP_NEXT;
        end else begin
          mreq_nxt = '{req: 1'b1, we: 1'b1, addr: rxp_r, wdata: sh_rx};
          if (mem_req.req && mem_gnt) begin
            mreq_nxt = '0;
            st_nxt   = sdp_pkg::SDP_NEXT;
          end
        end
      end
      sdp_pkg::SDP_NEXT: begin
        // Slot done: fetch and store precede count and pointer step
        if (use_tx) txp_nxt = ctrl1_r[sdp_pkg::CTRL1_TXSTEP] ?
                              txp_r + 12'h001 : txb_r;
        if (use_rx) rxp_nxt = ctrl1_r[sdp_pkg::CTRL1_RXSTEP] ?
                              rxp_r + 12'h001 : rxb_r;
        if (cnt_r == 10'h000) begin
          ctrl1_nxt[sdp_pkg::CTRL1_RUN] = 1'b0;
          irq_nxt = 1'b1;
          st_nxt  = sdp_pkg::SDP_IDLE;
        end else begin
          cnt_nxt = cnt_r - 10'h001;
          if (!wm_done_r && level != 11'h000 &&
              {1'b0, cnt_r} <= level) begin
            irq_nxt     = 1'b1;
            wm_done_nxt = 1'b1;
          end
          st_nxt = use_tx ? sdp_pkg::SDP_FETCH : sdp_pkg::SDP_SHIFT;
        end
      end
      default: st_nxt = sdp_pkg::SDP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_r   <= sdp_pkg::CTRL_RST;
      ctrl2_r   <= sdp_pkg::CTRL_RST;
      cnt_r     <= sdp_pkg::COUNT_RST;
      txp_r     <= sdp_pkg::PTR_RST;
      txb_r     <= sdp_pkg::PTR_RST;
      rxp_r     <= sdp_pkg::PTR_RST;
      rxb_r     <= sdp_pkg::PTR_RST;
      irq_r     <= 1'b0;
      wm_done_r <= 1'b0;
      txd_r     <= 8'h00;
      st_r      <= sdp_pkg::SDP_IDLE;
      mem_req   <= '0;
    end else begin
      ctrl1_r   <= ctrl1_nxt;
      ctrl2_r   <= ctrl2_nxt;
      cnt_r     <= cnt_nxt;
      txp_r     <= txp_nxt;
      txb_r     <= txb_nxt;
      rxp_r     <= rxp_nxt;
      rxb_r     <= rxb_nxt;
      irq_r     <= irq_nxt;
      wm_done_r <= wm_done_nxt;
      txd_r     <= txd_nxt;
      st_r      <= st_nxt;
      mem_req   <= mreq_nxt;
    end
  end

  assign serial_port_irq_flag = irq_r;

  //////////////////////////////////////////////////////////////////////////
  // Serial shifter
  sdp_shift #(.HALF_DIV(HALF_DIV)) u_shift (
    .clk     (clk),
    .rst_n   (rst_n),
    .slave   (ctrl1_r[sdp_pkg::CTRL1_SLAVE]),
    .start   (sh_start),
    .tx_byte (use_tx ? txd_r : 8'hFF),
    .done    (sh_done),
    .rx_byte (sh_rx),
    .sck_in  (sck_in),
    .sdi     (sdi),
    .sck_out (sck_out),
    .sck_oe  (sck_oe),
    .sdo     (sdo)
  );

  //////////////////////////////////////////////////////////////////////////
  // Checks
  run_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == sdp_pkg::SDP_NEXT && cnt_r == 10'h000)
      |=> !run && irq_r && st_r == sdp_pkg::SDP_IDLE)
    else $error("run bit not cleared at last byte");
  count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == sdp_pkg::SDP_NEXT && cnt_r != 10'h000 && !wr)
      |=> cnt_r == $past(cnt_r) - 10'h001)
    else $error("count did not decrement");
  no_tx_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == sdp_pkg::SDP_FETCH) |-> !(mem_req.req && mem_req.we))
    else $error("write during fetch");
  sfr_guard_a: assert property (@(posedge clk) disable iff (!rst_n)
    mem_req.req |-> mem_req.addr[11:8] != sdp_pkg::BANK_SFR_LO &&
                    mem_req.addr[11:8] != sdp_pkg::BANK_SFR_HI)
    else $error("access to protected bank");
  tx_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == sdp_pkg::SDP_NEXT && use_tx &&
     !ctrl1_r[sdp_pkg::CTRL1_TXSTEP] && !wr) |=> txp_r == $past(txb_r))
    else $error("tx pointer moved");
  rx_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == sdp_pkg::SDP_NEXT && use_rx &&
     ctrl1_r[sdp_pkg::CTRL1_RXSTEP] && !wr)
      |=> rxp_r == $past(rxp_r) + 12'h001)
    else $error("rx pointer did not step");
  wm_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wm_done_r && !irq_r && st_r == sdp_pkg::SDP_NEXT && cnt_r != 10'h000
     && !wr) |=> !irq_r)
    else $error("watermark flag set twice");
  wm_now_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && paddr == sdp_pkg::OFF_CTRL2 && run &&
     {1'b0, sdp_pkg::wm_level(pwdata[3:0])} > remain) |=> irq_r)
    else $error("immediate watermark flag missing");
  mem_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_req.req && !mem_gnt) |=> mem_req.req && $stable(mem_req.addr))
    else $error("request dropped before grant");
  sck_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r != sdp_pkg::SDP_SHIFT |-> !sck_out)
    else $error("serial clock outside a byte slot");
  irq_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (irq_r && !(wr && paddr == sdp_pkg::OFF_STATUS &&
     pwdata[sdp_pkg::STAT_IRQ])) |=> irq_r)
    else $error("port flag dropped without a clear");
  done_c: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(run));
  wm_c: cover property (@(posedge clk) disable iff (!rst_n)
    run && $rose(wm_done_r));
  store_c: cover property (@(posedge clk) disable iff (!rst_n)
    mem_req.req && mem_req.we && mem_gnt);
  slave_c: cover property (@(posedge clk) disable iff (!rst_n)
    ctrl1_r[sdp_pkg::CTRL1_SLAVE] && $fell(run));

endmodule

// File: sdp_pkg.sv
package sdp_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL1  = 8'h00;
  localparam logic [7:0] OFF_CTRL2  = 8'h04;
  localparam logic [7:0] OFF_COUNT  = 8'h08;
  localparam logic [7:0] OFF_TXPTR  = 8'h0C;
  localparam logic [7:0] OFF_RXPTR  = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // Control one field positions
  localparam int CTRL1_RUN    = 0;
  localparam int CTRL1_DLYIEN = 1;
  localparam int CTRL1_DIR_LO = 2;
  localparam int CTRL1_RXSTEP = 4;
  localparam int CTRL1_TXSTEP = 5;
  localparam int CTRL1_SLAVE  = 6;

  // Control two field positions
  localparam int CTRL2_WM_LO  = 0;
  localparam int CTRL2_DLY_LO = 4;

  // Status field positions
  localparam int STAT_IRQ  = 0;
  localparam int STAT_BUSY = 1;

  // Reset values
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [9:0]  COUNT_RST = 10'h000;
  localparam logic [11:0] PTR_RST   = 12'h000;

  // Protected register banks
  localparam logic [3:0] BANK_SFR_LO = 4'hE;
  localparam logic [3:0] BANK_SFR_HI = 4'hF;

  // Direction codes
  localparam logic [1:0] DIR_RX     = 2'h0;
  localparam logic [1:0] DIR_TX     = 2'h1;
  localparam logic [1:0] DIR_DUPLEX = 2'h2;

  // Master mode serial clock divider (clk cycles per half bit)
  localparam int SCK_HALF_DIV = 4;

  typedef enum logic [2:0] {
    SDP_IDLE, SDP_FETCH, SDP_SHIFT, SDP_STORE, SDP_NEXT
  } sdp_state_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } sdp_mem_req_t;

  // Watermark code to remaining byte level
  function automatic logic [9:0] wm_level(input logic [3:0] code);
    logic [9:0] lv;
    lv = 10'h000;
    unique case (code)
      4'h0: lv = 10'h000;
      4'h1: lv = 10'h001;
      4'h2: lv = 10'h002;
      4'h3: lv = 10'h004;
      4'h4: lv = 10'h008;
      4'h5: lv = 10'h010;
      4'h6: lv = 10'h020;
      4'h7: lv = 10'h043;
      4'h8: lv = 10'h080;
      4'h9: lv = 10'h0C0;
      4'hA: lv = 10'h100;
      4'hB: lv = 10'h140;
      4'hC: lv = 10'h180;
      4'hD: lv = 10'h1C0;
      4'hE: lv = 10'h200;
      4'hF: lv = 10'h240;
    endcase
    return lv;
  endfunction

endpackage

// File: sdp_shift.sv
// Serial byte shifter: master drives sck, slave follows a synchronised sck
module sdp_shift #(
  parameter int HALF_DIV = 4
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       slave,
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  output logic            done,
  output logic [7:0]      rx_byte,
  // Pins
  input  wire logic       sck_in,
  input  wire logic       sdi,
  output logic            sck_out,
  output logic            sck_oe,
  output logic            sdo
);

  logic       s1_r, s2_r, s3_r;
  logic       act_r, act_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] rx_nxt;
  logic       sck_r, sck_nxt;
  logic       done_nxt;
  logic [7:0] div_r, div_nxt;
  logic       d1_r, d2_r;
  logic       tick, rise, fall;

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      d1_r <= 1'b0;
      d2_r <= 1'b0;
    end else begin
      s1_r <= sck_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      d1_r <= sdi;
      d2_r <= d1_r;
    end
  end

  assign tick = (div_r == 8'(HALF_DIV - 1));
  assign rise = slave ? (s2_r & ~s3_r) : (tick & ~sck_r & act_r);
  assign fall = slave ? (~s2_r & s3_r) : (tick & sck_r & act_r);

  always_comb begin
    act_nxt  = act_r;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    rx_nxt   = rx_byte;
    sck_nxt  = sck_r;
    done_nxt = 1'b0;
    div_nxt  = (tick || !act_r) ? 8'h00 : div_r + 8'h01;
    if (start && !act_r) begin
      act_nxt = 1'b1;
      bit_nxt = 3'h0;
      sh_nxt  = tx_byte;
    end else if (act_r) begin
      if (!slave && tick) sck_nxt = ~sck_r;
      if (rise) sh_nxt = {sh_r[6:0], d2_r};
      if (fall) begin
        bit_nxt = bit_r + 3'h1;
        if (bit_r == 3'h7) begin
          act_nxt  = 1'b0;
          done_nxt = 1'b1;
          rx_nxt   = sh_r;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_r   <= 1'b0;
      bit_r   <= 3'h0;
      sh_r    <= 8'h00;
      rx_byte <= 8'h00;
      sck_r   <= 1'b0;
      done    <= 1'b0;
      div_r   <= 8'h00;
    end else begin
      act_r   <= act_nxt;
      bit_r   <= bit_nxt;
      sh_r    <= sh_nxt;
      rx_byte <= rx_nxt;
      sck_r   <= sck_nxt;
      done    <= done_nxt;
      div_r   <= div_nxt;
    end
  end

  assign sck_out = sck_r;
  assign sck_oe  = ~slave;
  assign sdo     = sh_r[7];

endmodule

// File: sdp_partner.sv
// Far side serial peripheral: answers in both roles, mode 0, MSB first
module sdp_partner (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Serial line
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic start,
  output logic      sck_gen,
  output logic      miso,
  // Captured byte
  output logic [7:0] rx_byte,
  output logic       rx_stb
);
  logic       sck_d;
  logic       go_d;
  logic       mosi_d;
  logic [2:0] bitc;
  logic [6:0] sh_in;
  logic [7:0] sh_out;
  logic [7:0] num;
  logic [6:0] gcnt;

  assign miso = sh_out[7];

  ////////////////////////////////////////////////////////////////////////////
  // Clock made only while a frame is asked for, idle low otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      go_d    <= 1'h0;
      gcnt    <= 7'h00;
      sck_gen <= 1'h0;
    end else begin
      go_d <= start;
      if (gcnt != 7'h00) begin
        gcnt <= gcnt - 7'h01;
        if (gcnt[1:0] == 2'h1) sck_gen <= ~sck_gen;
      end else if (start && !go_d) begin
        gcnt <= 7'h40;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample on rise with the data line as it stood at the rising edge,
  // shift on fall, next byte loaded after the eighth rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d   <= 1'h0;
      mosi_d  <= 1'h0;
      bitc    <= 3'h0;
      sh_in   <= 7'h00;
      sh_out  <= 8'h5A;
      num     <= 8'h5B;
      rx_byte <= 8'h00;
      rx_stb  <= 1'h0;
    end else begin
      sck_d  <= sck;
      mosi_d <= mosi;
      rx_stb <= 1'h0;
      if (sck && !sck_d) begin
        sh_in <= {sh_in[5:0], mosi_d};
        bitc  <= bitc + 3'h1;
        if (bitc == 3'h7) begin
          rx_byte <= {sh_in, mosi_d};
          rx_stb  <= 1'h1;
          sh_out  <= num;
          num     <= num + 8'h01;
        end
      end else if (!sck && sck_d && bitc != 3'h0) begin
        sh_out <= {sh_out[6:0], ~sh_out[0]};
      end
    end
  end
endmodule

// File: sdp_dma_tb.sv
module sdp_dma_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, mem_rdata, prx;
  logic [31:0] pwdata, prdata, r, st;
  logic        mem_gnt, sck_out, sck_oe, sdo, sdi, sck_gen, prx_stb, pgo;
  logic        serial_port_irq_flag;
  sdp_pkg::sdp_mem_req_t mem_req;
  logic [7:0]  ram [4096];
  logic [7:0]  txq [$];
  logic [19:0] rxq [$];
  logic [7:0]  pk;
  int          bad_count, checks;
  wire         sck = sck_oe ? sck_out : sck_gen;

  sdp_dma uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mem_req, .mem_gnt, .mem_rdata,
    .serial_port_irq_flag, .sck_in(sck_gen), .sdi, .sck_out, .sck_oe, .sdo);
  sdp_partner prt (.clk, .rst_n, .sck, .mosi(sdo), .start(pgo),
    .sck_gen, .miso(sdi), .rx_byte(prx), .rx_stb(prx_stb));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task report_and_stop;
    $display("bad_count=%0d checks=%0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // APB master
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) begin
      n++;
      if (n > 50) begin
        bad_count++;
        report_and_stop;
      end
      @(posedge clk);
    end
    r = prdata;
    chk(pslverr, 1'h0);
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  // Program a transaction and note every expected byte
  task automatic xfer(input logic [7:0] c1, input logic [7:0] c2,
    input logic [11:0] tp, input logic [11:0] rp, input logic [9:0] cnt);
    logic [11:0] a;
    apb(1'h1, sdp_pkg::OFF_CTRL2, {24'h0, c2});
    apb(1'h1, sdp_pkg::OFF_CTRL1, {24'h0, c1});
    apb(1'h1, sdp_pkg::OFF_TXPTR, {20'hC0000, tp});
    apb(1'h1, sdp_pkg::OFF_RXPTR, {20'hC0000, rp});
    apb(1'h1, sdp_pkg::OFF_COUNT, {22'h0, cnt});
    for (int i = 0; i <= cnt; i++) begin
      a = tp + (c1[5] ? 12'(i) : 12'h000);
      if (c1[3:2] == sdp_pkg::DIR_RX) txq.push_back(8'hFF);
      else txq.push_back(a[11:8] >= sdp_pkg::BANK_SFR_LO ? 8'h00 : ram[a]);
      a = rp + (c1[4] ? 12'(i) : 12'h000);
      if (c1[3:2] != sdp_pkg::DIR_TX && a[11:8] < sdp_pkg::BANK_SFR_LO)
        rxq.push_back({a, pk});
      pk++;
    end
    apb(1'h1, sdp_pkg::OFF_CTRL1, {24'h0, c1 | 8'h01});
  endtask

  // Poll to completion, flag quiet meanwhile, then check the end state
  task automatic wdone;
    int n = 0;
    apb(1'h0, sdp_pkg::OFF_STATUS, 32'h0);
    while (r[sdp_pkg::STAT_BUSY] === 1'h1) begin
      chk(r[sdp_pkg::STAT_IRQ], 1'h0);
      n++;
      if (n > 3000) begin
        bad_count++;
        report_and_stop;
      end
      apb(1'h0, sdp_pkg::OFF_STATUS, 32'h0);
    end
    chk(r[1:0], 2'h1);
    chk(serial_port_irq_flag, 1'h1);
    apb(1'h0, sdp_pkg::OFF_COUNT, 32'h0);
    chk(r, 32'h0);
    apb(1'h0, sdp_pkg::OFF_CTRL1, 32'h0);
    chk(r[0], 1'h0);
    chk(txq.size() + rxq.size(), 32'h0);
    apb(1'h1, sdp_pkg::OFF_STATUS, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Memory side and result watcher
  always @(posedge clk) begin
    st = xs(st);
    mem_rdata <= ram[mem_req.addr];
    mem_gnt <= mem_req.req && !mem_gnt && st[1:0] != 2'h0;
    if (mem_req.req && mem_gnt && mem_req.we) begin
      ram[mem_req.addr] <= mem_req.wdata;
      chk({mem_req.addr, mem_req.wdata},
          rxq.size() ? rxq.pop_front() : 20'hFFFFF);
    end
    if (mem_req.req) chk(mem_req.addr[11:8] < 4'hE, 1'h1);
    if (prx_stb) chk(prx, txq.size() ? txq.pop_front() : ~prx);
  end

  initial begin
    #900us;
    bad_count++;
    report_and_stop;
  end

  initial begin
    rst_n = 1'h0;
    {psel, penable, pwrite, pgo, mem_gnt} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    mem_rdata = 8'h00;
    {bad_count, checks} = 64'h0;
    pk = 8'h5A;
    st = 32'h470bdef2;
    for (int i = 0; i < 4096; i++) begin
      st = xs(st);
      ram[i] = st[7:0];
    end
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      apb(1'h0, 8'(4 * i), 32'h0);
      chk(r, 32'h0);
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, i ? sdp_pkg::OFF_RXPTR : sdp_pkg::OFF_TXPTR, 32'h80000A00);
      apb(1'h1, i ? sdp_pkg::OFF_RXPTR : sdp_pkg::OFF_TXPTR, 32'h4000005C);
      apb(1'h0, i ? sdp_pkg::OFF_RXPTR : sdp_pkg::OFF_TXPTR, 32'h0);
      chk(r, 32'hA5C);
    end
    xfer(8'h38, 8'h03, 12'h100, 12'h200, 10'h009);
    for (int n = 0; r[0] !== 1'h1; n++) begin
      if (n > 3000) begin
        bad_count++;
        report_and_stop;
      end
      apb(1'h0, sdp_pkg::OFF_STATUS, 32'h0);
    end
    chk(r[1:0], 2'h3);
    apb(1'h1, sdp_pkg::OFF_STATUS, 32'h1);
    wdone;
    xfer(8'h24, 8'h00, 12'hDFF, 12'h000, 10'h001);
    wdone;
    xfer(8'h10, 8'h00, 12'h000, 12'hDFF, 10'h001);
    wdone;
    xfer(8'h08, 8'h00, 12'h040, 12'h080, 10'h001);
    wdone;
    xfer(8'h38, 8'h50, 12'h300, 12'h400, 10'h00F);
    repeat (100) @(posedge clk);
    apb(1'h1, sdp_pkg::OFF_CTRL2, 32'h5F);
    apb(1'h0, sdp_pkg::OFF_STATUS, 32'h0);
    chk(r[1:0], 2'h3);
    apb(1'h0, sdp_pkg::OFF_CTRL2, 32'h0);
    chk(r, 32'h5F);
    apb(1'h1, sdp_pkg::OFF_STATUS, 32'h1);
    wdone;
    xfer(8'h78, 8'h00, 12'h500, 12'h600, 10'h001);
    repeat (60) @(posedge clk);
    apb(1'h0, sdp_pkg::OFF_COUNT, 32'h0);
    chk(r, 32'h1);
    chk(sck_oe, 1'h0);
    repeat (2) begin
      pgo <= 1'h1;
      repeat (90) @(posedge clk);
      pgo <= 1'h0;
      repeat (60) @(posedge clk);
    end
    wdone;
    report_and_stop;
  end
endmodule
